/* File: rtl/pcb_bank.v */
// configuration register bank of the power manager: four byte registers,
// the pin muxing, power-good delay, monitor blanking and load switch gating
// assumes a byte register port from the serial front end, the password
// state and apply triggers from elsewhere, and pins needing synchronising
// Function
// R1: push-button hold before reset is 8 s when bit clear, 15 s when set.
// R2: output pin two open-drain at 0, push-pull from switch-one supply at 1.
// R3: pairing 0: io pin one open-drain output; 1: io one input drives pin two.
// R4: power-good rise delay codes 0-3 give 10, 20, 50, 150 ms; reset code 1.
// R5: power-good falls at once on power-down or fault; delay is rise only.
// R6: tightness 1: tight thresholds plus overvoltage watch; 0: wide, no watch.
// R7: warm reset enable 1 makes io pin three a buck one/two warm reset input.
// R8: switch three current limit codes 0-3: 100/200/500/1000 mA, reset 0.
// R9: switch two current limit codes 0-3: 100/200/500/1000 mA, reset 0.
// R10: fail cutoff bit set turns its switch off while power-fail output low.
// R11: discharge bit set discharges the switch output while the switch is off.
// R12: all four registers take writes only after the password is done.
// R13: any buck one voltage write blanks over/undervoltage watch for 5 ms.
// R14: new buck one voltage applies only on either apply trigger bit.
// R15: bit 7 of buck one register enables pulse skip; 0 forces fixed freq.
// R16: voltage code maps 0.850 V +10 mV to 1.350 V, then +25 mV; reset 19h.
// R17: io pin three output bit is ignored while warm reset enable is set.
// R18: io one and pin two output bits are ignored while pairing is set.
// R19: reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`include "pcb_defines.vh"
module pcb_bank #(
  parameter [31:0] PB_SHORT_CYC = `PCB_PB_SHORT_MS * `PCB_CLK_KHZ,
  parameter [31:0] PB_LONG_CYC = `PCB_PB_LONG_MS * `PCB_CLK_KHZ,
  parameter [31:0] PGD0_CYC = `PCB_PGD0_MS * `PCB_CLK_KHZ,
  parameter [31:0] PGD1_CYC = `PCB_PGD1_MS * `PCB_CLK_KHZ,
  parameter [31:0] PGD2_CYC = `PCB_PGD2_MS * `PCB_CLK_KHZ,
  parameter [31:0] PGD3_CYC = `PCB_PGD3_MS * `PCB_CLK_KHZ,
  parameter [31:0] BLANK_CYC = `PCB_BLANK_MS * `PCB_CLK_KHZ,
  parameter NSW = 3
) (
  input wire i_clk,
  input wire i_rstn,
  // register port
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_pw_ok,
  output reg [7:0] o_rdata,
  output reg o_wr_refused,
  // apply triggers and enable-register bits held elsewhere
  input wire i_apply_go,
  input wire i_apply_alt,
  input wire i_gpo1_bit,
  input wire i_output_pin_two_bit,
  input wire i_gpo3_bit,
  input wire [NSW-1:0] i_ls_en,
  // rails state from the sequencer, same clock
  input wire i_rails_up,
  input wire i_fault,
  // pins
  input wire i_pb_n,
  input wire i_power_fail_output_low_n,
  input wire i_io_pin_one,
  output reg o_io_pin_one,
  output reg o_io_pin_one_oe_n,
  output reg o_output_pin_two,
  output reg o_output_pin_two_oe_n,
  output reg o_out2_from_supply,
  input wire i_io_pin_three,
  output reg o_io_pin_three,
  output reg o_io_pin_three_oe_n,
  // to the analog side
  output reg o_pb_reset,
  output reg o_power_good,
  output reg o_sup_tight,
  output reg o_ov_watch,
  output reg o_uv_watch,
  output reg o_buck_warm_rst,
  output reg [1:0] o_switch_three_current_limit,
  output reg [1:0] o_switch_two_current_limit,
  output reg [NSW-1:0] o_ls_on,
  output reg [NSW-1:0] o_ls_discharge,
  output reg o_pulse_skip_enable,
  output reg [5:0] o_buck_vsel,
  output reg [10:0] o_buck_mv,
  output reg [1:0] o_uvlo_sel,
  output reg o_uvlo_hys
);

  // registers
  reg [7:0] pwr_cfg_r;
  reg [7:0] sw_cfg_r;
  reg [7:0] sw_fail_r;
  reg [7:0] buck1_r;
  reg [5:0] vsel_applied_r;

  // write decode
  wire wr_hit;
  wire wr_ok;
  wire buck_wr;
  assign wr_hit = (i_addr == `PCB_ADDR_PWR_CFG) || (i_addr == `PCB_ADDR_SW_CFG) ||
                  (i_addr == `PCB_ADDR_SW_FAIL) || (i_addr == `PCB_ADDR_BUCK1);
  assign wr_ok = i_wr_en && wr_hit && i_pw_ok; // [R12]
  assign buck_wr = wr_ok && (i_addr == `PCB_ADDR_BUCK1);

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      pwr_cfg_r <= `PCB_RST_PWR_CFG;
      sw_cfg_r <= `PCB_RST_SW_CFG;
      sw_fail_r <= `PCB_RST_SW_FAIL;
      buck1_r <= `PCB_RST_BUCK1;
      o_wr_refused <= 1'b0;
    end else begin
      // refusal flagged for one cycle so the front end can nack
      o_wr_refused <= i_wr_en && wr_hit && !i_pw_ok; // [R12]
      if (wr_ok) begin
        case (i_addr)
          `PCB_ADDR_PWR_CFG: pwr_cfg_r <= i_wdata & `PCB_MASK_PWR_CFG;
          `PCB_ADDR_SW_CFG: sw_cfg_r <= i_wdata & `PCB_MASK_SW_CFG; // [R19]
          `PCB_ADDR_SW_FAIL: sw_fail_r <= i_wdata & `PCB_MASK_SW_FAIL; // [R19]
          `PCB_ADDR_BUCK1: buck1_r <= i_wdata & `PCB_MASK_BUCK1; // [R19]
          default: pwr_cfg_r <= pwr_cfg_r;
        endcase
      end
    end
  end

  // read port, one cycle latency, unmapped reads zero
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      case (i_addr)
        `PCB_ADDR_PWR_CFG: o_rdata <= pwr_cfg_r;
        `PCB_ADDR_SW_CFG: o_rdata <= sw_cfg_r & `PCB_MASK_SW_CFG; // [R19]
        `PCB_ADDR_SW_FAIL: o_rdata <= sw_fail_r & `PCB_MASK_SW_FAIL; // [R19]
        `PCB_ADDR_BUCK1: o_rdata <= buck1_r & `PCB_MASK_BUCK1; // [R19]
        default: o_rdata <= 8'h00;
      endcase
    end
  end

  // voltage code held until an apply trigger; the code register alone
  // must not move the rail
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      vsel_applied_r <= `PCB_RST_BUCK1_VSEL;
    end else if (i_apply_go || i_apply_alt) begin
      vsel_applied_r <= buck1_r[`PCB_VSEL_HI:0]; // [R14]
    end
  end

  // millivolt view of the applied code
  reg [10:0] mv_nxt;
  always @* begin
    mv_nxt = `PCB_MV_BASE;
    if (vsel_applied_r <= `PCB_VSEL_BREAK) begin
      mv_nxt = `PCB_MV_BASE + `PCB_MV_FINE * {5'h00, vsel_applied_r}; // [R16]
    end else begin
      mv_nxt = `PCB_MV_BREAK +
               `PCB_MV_COARSE * {5'h00, vsel_applied_r - `PCB_VSEL_BREAK}; // [R16]
    end
  end

  // pin synchronisers
  reg pb_s1_r, pb_s2_r;
  reg pfo_s1_r, pfo_s2_r;
  reg io1_s1_r, io1_s2_r;
  reg io3_s1_r, io3_s2_r;
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      pb_s1_r <= 1'b1;
      pb_s2_r <= 1'b1;
      pfo_s1_r <= 1'b1;
      pfo_s2_r <= 1'b1;
      io1_s1_r <= 1'b1;
      io1_s2_r <= 1'b1;
      io3_s1_r <= 1'b1;
      io3_s2_r <= 1'b1;
    end else begin
      pb_s1_r <= i_pb_n;
      pb_s2_r <= pb_s1_r;
      pfo_s1_r <= i_power_fail_output_low_n;
      pfo_s2_r <= pfo_s1_r;
      io1_s1_r <= i_io_pin_one;
      io1_s2_r <= io1_s1_r;
      io3_s1_r <= i_io_pin_three;
      io3_s2_r <= io3_s1_r;
    end
  end

  // push-button hold timer: one reset pulse per press
  reg [31:0] pb_cnt_r;
  reg pb_fired_r;
  wire [31:0] pb_limit;
  assign pb_limit = pwr_cfg_r[`PCB_BIT_PB_HOLD] ? PB_LONG_CYC : PB_SHORT_CYC; // [R1]
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      pb_cnt_r <= 32'h0000_0000;
      pb_fired_r <= 1'b0;
      o_pb_reset <= 1'b0;
    end else begin
      o_pb_reset <= 1'b0;
      if (pb_s2_r) begin
        pb_cnt_r <= 32'h0000_0000;
        pb_fired_r <= 1'b0;
      end else if (!pb_fired_r) begin
        if (pb_cnt_r >= pb_limit - 32'h0000_0001) begin
          o_pb_reset <= 1'b1; // [R1]
          pb_fired_r <= 1'b1;
        end else begin
          pb_cnt_r <= pb_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  // power-good delay
  wire rails_ok;
  wire pgd_busy;
  wire pgd_done;
  wire pgd_start;
  reg [31:0] pgd_load;
  assign rails_ok = i_rails_up && !i_fault;
  assign pgd_start = rails_ok && !o_power_good && !pgd_busy && !pgd_done;
  always @* begin
    case (pwr_cfg_r[`PCB_PGD_HI:`PCB_PGD_LO])
      2'h0: begin
        pgd_load = PGD0_CYC; // [R4]
      end
      2'h1: begin
        pgd_load = PGD1_CYC; // [R4]
      end
      2'h2: begin
        pgd_load = PGD2_CYC; // [R4]
      end
      default: begin
        pgd_load = PGD3_CYC; // [R4]
      end
    endcase
  end

  pcb_timer #(
    .W(32)
  ) u_pgd_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(pgd_start),
    .i_abort(!rails_ok),
    .i_load(pgd_load),
    .o_busy(pgd_busy),
    .o_done(pgd_done)
  );

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_power_good <= 1'b0;
    end else if (!rails_ok) begin
      o_power_good <= 1'b0; // [R5]
    end else if (pgd_done) begin
      o_power_good <= 1'b1; // [R4]
    end
  end

  // monitor blanking after a buck one write; a second write restarts it
  wire blank_busy;
  pcb_timer #(
    .W(32)
  ) u_blank_timer (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_start(buck_wr), // [R13]
    .i_abort(1'b0),
    .i_load(BLANK_CYC),
    .o_busy(blank_busy),
    .o_done()
  );

  // pin muxing
  wire pairing;
  wire warm_en;
  wire out2_src;
  assign pairing = pwr_cfg_r[`PCB_BIT_PAIRING];
  assign warm_en = sw_cfg_r[`PCB_BIT_WARM_EN];
  assign out2_src = pairing ? io1_s2_r : i_output_pin_two_bit; // [R3] [R18]

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_io_pin_one <= 1'b0;
      o_io_pin_one_oe_n <= 1'b1;
      o_output_pin_two <= 1'b0;
      o_output_pin_two_oe_n <= 1'b1;
      o_out2_from_supply <= 1'b0;
      o_io_pin_three <= 1'b0;
      o_io_pin_three_oe_n <= 1'b1;
      o_buck_warm_rst <= 1'b0;
    end else begin
      // io one: released as input when paired, else low or released
      o_io_pin_one <= 1'b0;
      o_io_pin_one_oe_n <= pairing ? 1'b1 : i_gpo1_bit; // [R3] [R18]
      if (pwr_cfg_r[`PCB_BIT_OUT2_DRV]) begin
        o_output_pin_two <= out2_src; // [R2]
        o_output_pin_two_oe_n <= 1'b0;
        o_out2_from_supply <= 1'b1;
      end else begin
        o_output_pin_two <= 1'b0; // [R2]
        o_output_pin_two_oe_n <= out2_src;
        o_out2_from_supply <= 1'b0;
      end
      // io three: warm reset input, active low, or open-drain output
      o_io_pin_three <= 1'b0;
      o_io_pin_three_oe_n <= warm_en ? 1'b1 : i_gpo3_bit; // [R7] [R17]
      o_buck_warm_rst <= warm_en && !io3_s2_r; // [R7]
    end
  end

  // supervisor and converter settings
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sup_tight <= 1'b1;
      o_ov_watch <= 1'b0;
      o_uv_watch <= 1'b0;
      o_switch_three_current_limit <= 2'h0;
      o_switch_two_current_limit <= 2'h0;
      o_pulse_skip_enable <= 1'b1;
      o_buck_vsel <= `PCB_RST_BUCK1_VSEL;
      o_buck_mv <= 11'h000;
      o_uvlo_sel <= 2'h0;
      o_uvlo_hys <= 1'b1;
    end else begin
      o_sup_tight <= pwr_cfg_r[`PCB_BIT_TIGHT]; // [R6]
      o_ov_watch <= pwr_cfg_r[`PCB_BIT_TIGHT] && !blank_busy && !buck_wr; // [R6] [R13]
      o_uv_watch <= !blank_busy && !buck_wr; // [R13]
      o_switch_three_current_limit <= sw_cfg_r[`PCB_LS3_ILIM_HI:`PCB_LS3_ILIM_LO]; // [R8]
      o_switch_two_current_limit <= sw_cfg_r[`PCB_LS2_ILIM_HI:`PCB_LS2_ILIM_LO]; // [R9]
      o_pulse_skip_enable <= buck1_r[`PCB_BIT_PULSE_SKIP]; // [R15]
      o_buck_vsel <= vsel_applied_r; // [R14]
      o_buck_mv <= mv_nxt; // [R16]
      o_uvlo_sel <= pwr_cfg_r[`PCB_UVLO_HI:0];
      o_uvlo_hys <= sw_cfg_r[`PCB_BIT_UVLO_HYS];
    end
  end

  // load switch gating, one slice per switch
  genvar g;
  generate
    for (g = 0; g < NSW; g = g + 1) begin : g_sw
      wire cut;
      wire on_nxt;
      assign cut = sw_fail_r[`PCB_CUTOFF_LO + g] && !pfo_s2_r; // [R10]
      assign on_nxt = i_ls_en[g] && !cut;
      always @(posedge i_clk) begin
        if (!i_rstn) begin
          o_ls_on[g] <= 1'b0;
          o_ls_discharge[g] <= 1'b0;
        end else begin
          o_ls_on[g] <= on_nxt; // [R10]
          o_ls_discharge[g] <= sw_fail_r[`PCB_DISCH_LO + g] && !on_nxt; // [R11]
        end
      end
    end
  endgenerate

endmodule

/* File: pkg/pcb_defines.vh */
// register offsets, field positions, reset values and timing figures
// for the configuration register bank; definitions only
`ifndef PCB_DEFINES_VH
`define PCB_DEFINES_VH

// register offsets
`define PCB_ADDR_PWR_CFG 8'h13
`define PCB_ADDR_SW_CFG 8'h14
`define PCB_ADDR_SW_FAIL 8'h15
`define PCB_ADDR_BUCK1 8'h16

// reset values
`define PCB_RST_PWR_CFG 8'h4C
`define PCB_RST_SW_CFG 8'hC0
`define PCB_RST_SW_FAIL 8'h00
`define PCB_RST_BUCK1 8'h99
`define PCB_RST_BUCK1_VSEL 6'h19

// writable bit masks, reserved bits clear
`define PCB_MASK_PWR_CFG 8'hFF
`define PCB_MASK_SW_CFG 8'hCF
`define PCB_MASK_SW_FAIL 8'h3F
`define PCB_MASK_BUCK1 8'hBF

// power_config_primary fields, then the switch_config_limits hysteresis bit (bit 6)
`define PCB_BIT_PB_HOLD 7
`define PCB_BIT_OUT2_DRV 6
`define PCB_BIT_PAIRING 5
`define PCB_PGD_HI 4
`define PCB_PGD_LO 3
`define PCB_BIT_TIGHT 2
`define PCB_UVLO_HI 1
`define PCB_BIT_UVLO_HYS 6
// switch_config_limits fields
`define PCB_BIT_WARM_EN 7
`define PCB_LS3_ILIM_HI 3
`define PCB_LS3_ILIM_LO 2
`define PCB_LS2_ILIM_HI 1
`define PCB_LS2_ILIM_LO 0
// switch_fail_discharge fields
`define PCB_CUTOFF_LO 3
`define PCB_DISCH_LO 0
// buck_one_voltage fields
`define PCB_BIT_PULSE_SKIP 7
`define PCB_VSEL_HI 5

// buck one voltage map, in millivolts
`define PCB_VSEL_BREAK 6'h32
`define PCB_MV_BASE 11'h352
`define PCB_MV_FINE 11'h00A
`define PCB_MV_BREAK 11'h546
`define PCB_MV_COARSE 11'h019

// timing: clock in kHz, so ms times kHz gives cycles
`define PCB_CLK_KHZ 32'h0003_0D40
`define PCB_PB_SHORT_MS 32'h0000_1F40
`define PCB_PB_LONG_MS 32'h0000_3A98
`define PCB_PGD0_MS 32'h0000_000A
`define PCB_PGD1_MS 32'h0000_0014
`define PCB_PGD2_MS 32'h0000_0032
`define PCB_PGD3_MS 32'h0000_0096
`define PCB_BLANK_MS 32'h0000_0005

`endif

/* File: rtl/pcb_timer.v */
// reloadable one-shot down counter
// assumes one clock; start reloads even while running, abort wins over start
`timescale 1ns/100ps
module pcb_timer #(
  parameter W = 32
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_start,
  input wire i_abort,
  input wire [W-1:0] i_load,
  output reg o_busy,
  output reg o_done
);
  reg [W-1:0] cnt_r;

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_r <= {W{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_abort) begin
        cnt_r <= {W{1'b0}};
        o_busy <= 1'b0;
      end else if (i_start) begin
        // a load of zero still costs one cycle
        cnt_r <= i_load;
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: dv/pcb_bank_sva.sv */
// port assertions for the configuration register bank
// assumes a bind to pcb_bank with blanking of at least 7 cycles
`timescale 1ns/100ps
module pcb_bank_sva (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_wr_en,
  input wire logic [7:0] i_addr,
  input wire logic i_pw_ok,
  input wire logic o_wr_refused,
  input wire logic i_apply_go,
  input wire logic i_apply_alt,
  input wire logic i_rails_up,
  input wire logic i_fault,
  input wire logic o_power_good,
  input wire logic o_ov_watch,
  input wire logic o_uv_watch,
  input wire logic o_pb_reset,
  input wire logic o_buck_warm_rst,
  input wire logic o_io_pin_three_oe_n,
  input wire logic [2:0] i_ls_en,
  input wire logic [2:0] o_ls_on,
  input wire logic [2:0] o_ls_discharge,
  input wire logic [5:0] o_buck_vsel,
  input wire logic [10:0] o_buck_mv
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_buck_wr;
    i_wr_en && i_pw_ok && i_addr == 8'h16;
  endsequence
  sequence s_blank;
    !o_ov_watch && !o_uv_watch;
  endsequence
  chk_refuse_pulse: assert property (
    i_wr_en && !i_pw_ok && i_addr inside {[8'h13:8'h16]} |=> o_wr_refused)
    else $error("refused write not flagged");
  chk_refuse_cause: assert property (
    o_wr_refused |-> $past(i_wr_en) && !$past(i_pw_ok))
    else $error("refusal flag without a refused write");
  chk_blank_watch: assert property (s_buck_wr |=> s_blank [*8])
    else $error("monitoring not blanked after voltage write");
  chk_pg_fall: assert property ((!i_rails_up || i_fault) |=> !o_power_good)
    else $error("power good fell late");
  chk_pg_rise: assert property (
    $rose(o_power_good) |-> $past(i_rails_up) && $past(i_rails_up, 8))
    else $error("power good rose without a delay");
  chk_warm_pin: assert property (o_buck_warm_rst |-> o_io_pin_three_oe_n)
    else $error("pin three driven while used as warm reset");
  chk_disch_off: assert property ((o_ls_discharge & o_ls_on) == 3'h0)
    else $error("discharge on a switch that is on");
  chk_ls_gate: assert property ((i_ls_en == 3'h0) [*3] |-> o_ls_on == 3'h0)
    else $error("switch on without enable");
  chk_vsel_apply: assert property ($changed(o_buck_vsel) |->
    $past(i_apply_go, 2) || $past(i_apply_alt, 2) || $past(i_apply_go) || $past(i_apply_alt))
    else $error("voltage code changed without apply");
  chk_mv_map: assert property ($past(i_rstn) |-> o_buck_mv == (o_buck_vsel <= 6'h32 ?
    11'h352 + 11'h00A * o_buck_vsel : 11'h546 + 11'h019 * (o_buck_vsel - 6'h32)))
    else $error("millivolt value does not match code");
  chk_pb_once: assert property (o_pb_reset |=> !o_pb_reset)
    else $error("button reset pulse too long");
endmodule
bind pcb_bank pcb_bank_sva u_pcb_bank_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_wr_en(i_wr_en),
  .i_addr(i_addr), .i_pw_ok(i_pw_ok), .o_wr_refused(o_wr_refused), .i_apply_go(i_apply_go),
  .i_apply_alt(i_apply_alt), .i_rails_up(i_rails_up), .i_fault(i_fault),
  .o_power_good(o_power_good), .o_ov_watch(o_ov_watch), .o_uv_watch(o_uv_watch),
  .o_pb_reset(o_pb_reset), .o_buck_warm_rst(o_buck_warm_rst),
  .o_io_pin_three_oe_n(o_io_pin_three_oe_n), .i_ls_en(i_ls_en), .o_ls_on(o_ls_on),
  .o_ls_discharge(o_ls_discharge), .o_buck_vsel(o_buck_vsel), .o_buck_mv(o_buck_mv));

/* File: dv/pcb_host.sv */
// host model driving the byte register port of the bank
// assumes the bench calls wr and rd one at a time
`timescale 1ns/100ps
module pcb_host (
  input wire logic i_clk,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_pw_ok,
  output logic o_rd_vld
);
  initial begin
    {o_wr_en, o_rd_en, o_addr, o_wdata, o_pw_ok, o_rd_vld} = '0;
  end
  // pw low models a host that skipped the password procedure
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic pw);
    @(negedge i_clk);
    o_pw_ok = pw;
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    // released bus shows the inverse, never a stale value
    o_wdata = ~d;
    o_addr = ~a;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    @(negedge i_clk);
    o_rd_vld = 1'b1;
    @(negedge i_clk);
    o_rd_vld = 1'b0;
  endtask
endmodule

/* File: dv/test_pcb_bank.sv */
// bench for the register bank; reads are checked from a queue by a monitor
// assumes small timing parameters so every delay fits a short run
`timescale 1ns/100ps
module test_pcb_bank;
  localparam int PG[4] = '{20, 30, 40, 50};
  localparam int PB[2] = '{20, 40};
  localparam logic [7:0] MSK[5] = '{8'hFF, 8'hCF, 8'h3F, 8'hBF, 8'h00};
  localparam logic [5:0] VS[3] = '{6'h00, 6'h32, 6'h3F};
  localparam logic [10:0] MV[3] = '{11'h352, 11'h546, 11'h68B};
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_wr_en, i_rd_en, i_pw_ok, rd_vld, i_apply_go, i_apply_alt, i_gpo1_bit;
  logic i_output_pin_two_bit, i_gpo3_bit, i_rails_up, i_fault, i_pb_n, i_io_pin_one;
  logic i_power_fail_output_low_n, i_io_pin_three, o_io_pin_one, o_io_pin_one_oe_n;
  logic o_output_pin_two, o_output_pin_two_oe_n, o_out2_from_supply, o_io_pin_three;
  logic o_io_pin_three_oe_n, o_wr_refused, o_pb_reset, o_power_good, o_sup_tight;
  logic o_ov_watch, o_uv_watch, o_buck_warm_rst, o_pulse_skip_enable, o_uvlo_hys;
  logic [1:0] o_switch_three_current_limit, o_switch_two_current_limit, o_uvlo_sel;
  logic [2:0] i_ls_en, o_ls_on, o_ls_discharge;
  logic [5:0] o_buck_vsel, app;
  logic [10:0] o_buck_mv;
  logic [7:0] i_addr, i_wdata, o_rdata, d;
  logic [7:0] cur[5];
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  int cyc = 0;
  int seed;
  pcb_host u_pcb_host (.i_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_addr(i_addr),
    .o_wdata(i_wdata), .o_pw_ok(i_pw_ok), .o_rd_vld(rd_vld));
  pcb_bank #(.PB_SHORT_CYC(PB[0]), .PB_LONG_CYC(PB[1]), .PGD0_CYC(PG[0]), .PGD1_CYC(PG[1]),
    .PGD2_CYC(PG[2]), .PGD3_CYC(PG[3]), .BLANK_CYC(30)) u_pcb_bank (.*);
  initial forever #2.5 i_clk = ~i_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict;
    end else if (rd_vld === 1'b1) begin
      check(32'(o_rdata), exp_q.pop_front());
    end
  end
  task automatic tick(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(32'(e));
    u_pcb_host.rd(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_pcb_host.wr(a, v, 1'b1);
    tick(4);
  endtask
  // sampled 1 ns after the edge so a one-cycle pulse is seen settled
  task automatic wait_hi(input bit pb);
    n = 0;
    while ((pb ? o_pb_reset : o_power_good) !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask
  initial begin
    seed = 32'h7F57B496;
    {i_apply_go, i_apply_alt, i_rails_up, i_fault, i_io_pin_one, i_io_pin_three} = '0;
    {i_gpo1_bit, i_output_pin_two_bit, i_gpo3_bit, i_pb_n, i_power_fail_output_low_n} = '1;
    i_ls_en = 3'h0;
    cur = '{8'h4C, 8'hC0, 8'h00, 8'h99, 8'h00};
    app = 6'h19;
    tick(5);
    i_rstn = 1'b1;
    for (int i = 0; i < 5; i++) rd_exp(8'(8'h13 + i), cur[i]);
    $display("test reset values done");
    for (int i = 0; i < 15; i++) begin
      d = 8'($random(seed));
      {i_gpo1_bit, i_output_pin_two_bit, i_gpo3_bit, i_ls_en} = d[5:0];
      u_pcb_host.wr(8'(8'h13 + i % 5), d, 1'b1);
      cur[i % 5] = d & MSK[i % 5];
      rd_exp(8'(8'h13 + i % 5), cur[i % 5]);
    end
    for (int i = 0; i < 4; i++) begin
      u_pcb_host.wr(8'(8'h13 + i), ~cur[i], 1'b0);
      rd_exp(8'(8'h13 + i), cur[i]);
    end
    $display("test write and refusal done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h16, {2'b00, VS[i]});
      check(32'({o_uv_watch, o_pulse_skip_enable, o_buck_vsel}), 32'(app));
      if (i == 1) i_apply_alt = 1'b1;
      else i_apply_go = 1'b1;
      @(negedge i_clk);
      i_apply_go = 1'b0;
      i_apply_alt = 1'b0;
      tick(3);
      app = VS[i];
      check(32'({o_buck_mv, o_buck_vsel}), 32'({MV[i], app}));
    end
    $display("test buck voltage done");
    wr(8'h14, 8'h0E);
    i_gpo3_bit = 1'b0;
    tick(4);
    d = {2'b00, o_io_pin_three, o_switch_three_current_limit, o_switch_two_current_limit,
      o_io_pin_three_oe_n};
    check(32'(d), 32'h1C);
    wr(8'h14, 8'h80);
    d = {3'b000, o_io_pin_three_oe_n, o_buck_warm_rst, o_uvlo_sel, o_uvlo_hys};
    check(32'(d), 32'({5'b00011, cur[0][1:0], 1'b0}));
    wr(8'h15, 8'h3F);
    i_ls_en = 3'h7;
    i_power_fail_output_low_n = 1'b1;
    tick(5);
    check(32'({o_ls_on, o_ls_discharge}), 32'h38);
    i_power_fail_output_low_n = 1'b0;
    tick(5);
    check(32'({o_ls_on, o_ls_discharge}), 32'h07);
    i_power_fail_output_low_n = 1'b1;
    $display("test switches and pins done");
    wr(8'h13, 8'h64);
    for (int v = 0; v < 2; v++) begin
      i_io_pin_one = v[0];
      i_output_pin_two_bit = ~v[0];
      tick(5);
      d = {1'b0, o_ov_watch, o_uv_watch, o_io_pin_one, o_io_pin_one_oe_n, o_output_pin_two,
        o_out2_from_supply, o_output_pin_two_oe_n};
      check(32'(d), 32'({5'b01101, v[0], 2'b10}));
    end
    // open-drain pin two, unpaired pin one, wide thresholds
    wr(8'h13, 8'h00);
    {i_gpo1_bit, i_output_pin_two_bit} = 2'b01;
    tick(2);
    d = {2'b00, o_sup_tight, o_ov_watch, o_io_pin_one_oe_n, o_output_pin_two,
      o_output_pin_two_oe_n, o_out2_from_supply};
    check(32'(d), 32'h02);
    for (int c = 0; c < 4; c++) begin
      i_rails_up = 1'b0;
      wr(8'h13, 8'(8'h44 | (c << 3)));
      i_rails_up = 1'b1;
      wait_hi(1'b0);
      check(32'(n >= PG[c] && n <= PG[c] + 4), 32'h1);
      @(negedge i_clk);
      i_fault = 1'b1;
      tick(2);
      check(32'(o_power_good), 32'h0);
      i_fault = 1'b0;
    end
    $display("test power good done");
    for (int b = 0; b < 2; b++) begin
      wr(8'h13, b ? 8'hC4 : 8'h44);
      i_pb_n = 1'b0;
      wait_hi(1'b1);
      check(32'(n >= PB[b] && n <= PB[b] + 6), 32'h1);
      @(negedge i_clk);
      i_pb_n = 1'b1;
      tick(4);
    end
    $display("test push button done");
    print_verdict;
  end
endmodule
